// file: inc/sar_adc_consts.vh
// Constants for the successive-approximation converter control block
// Summary of operation
// - Converter runs only while enable bit set
// - Conversion clock divided down from system clock
// - Never exceed 200 ksps conversion rate
// - Writing start bit begins one conversion
// - Completion clears start, sets flag, loads result
// - Result is unsigned Vin times 1024 over VDD
// - Channel field picks one of eight pins
// - Interrupt needs flag, converter and global enables; masked status events interrupt with the global enable alone
// - No conversions in idle or power-down mode
// - Fastest setting takes 60 clocks per conversion
// - Speed 00..11 divide by 60,120,180,240
// - Justify bit selects result byte layout
// - Start not clearable; no start while busy/flagged
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

// Register word indices; byte address is index times four
`define REG_CTRL    3'h0
`define REG_AUX     3'h1
`define REG_RES_HI  3'h2
`define REG_RES_LO  3'h3
`define REG_IRQ_EN  3'h4
`define REG_STATUS  3'h5
`define REG_MASK    3'h6
`define REG_STATE   3'h7

// Control register fields
`define CTRL_EN     7
`define CTRL_SPD_HI 6
`define CTRL_SPD_LO 5
`define CTRL_DONE   4
`define CTRL_START  3
`define CTRL_CHS_HI 2
`define CTRL_CHS_LO 0

// Other fields
`define AUX_JUSTIFY 2
`define IEN_CONV    0
`define IEN_GLOBAL  1
`define EVT_DONE    0
`define EVT_REFUSED 1
`define EVT_W       2

// Reset values
`define CTRL_RST    8'h00
`define AUX_RST     8'h00
`define RES_RST     8'h00

// Timing
`define STEP_BASE   8'h05
`define SAR_BITS    10
`define SAR_TOP     10'h200
`define CLK_MHZ     25
`define MIN_CONV_NS 5000
`define MIN_CONV_CYC ((`MIN_CONV_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: hw/conv_step_timer.v
// Conversion step tick generator divided from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.vh"

module conv_step_timer
(
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // Control
   input  wire       run,
   input  wire [1:0] speed,
   // Step pulse
   output wire       tick
);

   reg  [7:0] cnt;
   wire [7:0] limit;

   // Twelve steps per conversion: 60, 120, 180 or 240 clocks
   assign limit = `STEP_BASE * ({6'h00, speed} + 8'h01);
   assign tick  = run && (cnt == limit - 8'h01);

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 8'h00;
      else if (!run || tick)
         cnt <= 8'h00;
      else
         cnt <= cnt + 8'h01;
   end

endmodule // conv_step_timer
`default_nettype wire

// file: hw/sar_register.v
// Successive-approximation register driving the trial code
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.vh"

module sar_register
(
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // Control
   input  wire       clear,
   input  wire       step,
   input  wire       cmp_high,
   // Outputs
   output reg  [9:0] trial,
   output reg  [9:0] result,
   output wire       last
);

   reg  [9:0] ptr;
   wire [9:0] keep;

   // Keep the trial bit when input is at or above the trial level
   assign keep = cmp_high ? trial : (trial & ~ptr);
   assign last = ptr[0];

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trial  <= 10'h000;
         ptr    <= 10'h000;
         result <= 10'h000;
      end
      else if (clear)
      begin
         trial <= `SAR_TOP;
         ptr   <= `SAR_TOP;
      end
      else if (step)
      begin
         trial <= keep | (ptr >> 1);
         ptr   <= ptr >> 1;
         if (ptr[0])
            result <= keep;
      end
   end

endmodule // sar_register
`default_nettype wire

// file: hw/sar_adc_conversion_control.v
// Converter control: register slave, sequencer and interrupt logic
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.vh"

module sar_adc_conversion_control
(
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // Register bus
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Power modes
   input  wire        idle_mode,
   input  wire        power_down_mode,
   // Analog front end
   output reg         converter_on_bit,
   output reg  [2:0]  analog_input_mux,
   output reg         sample_hold,
   output wire [9:0]  dac_code,
   input  wire        cmp_high,
   // Interrupt
   output wire        irq
);

   localparam [3:0] S_IDLE   = 4'b0001;
   localparam [3:0] S_SAMPLE = 4'b0010;
   localparam [3:0] S_CONV   = 4'b0100;
   localparam [3:0] S_LOAD   = 4'b1000;

   // Minimum start spacing, cut to the counter width on purpose
   localparam integer THROTTLE_FULL = `MIN_CONV_CYC;
   localparam [7:0]   THROTTLE      = THROTTLE_FULL[7:0];
   localparam [7:0]   CTRL_INIT     = `CTRL_RST;

   // Software visible state
   reg                converter_enable;
   reg  [1:0]         conv_speed_sel;
   reg                conversion_done_flag;
   reg                conversion_start;
   reg  [2:0]         input_channel_select;
   reg                result_justify_sel;
   reg  [7:0]         result_high_byte;
   reg  [7:0]         result_low_byte;
   reg                converter_irq_enable;
   reg                global_irq_enable;
   reg  [`EVT_W-1:0]  irq_status;
   reg  [`EVT_W-1:0]  irq_mask;

   // Sequencer
   reg  [3:0]         state;
   reg  [3:0]         next_state;
   reg  [1:0]         run_speed;
   reg  [7:0]         rate_cnt;
   reg                ack;

   wire [2:0]         widx;
   wire               wr_go;
   wire               rd_go;
   wire               wr_lane0;
   wire [7:0]         wbyte;
   wire               run_ok;
   wire               start_req;
   wire               start_ok;
   wire               step_tick;
   wire               sar_last;
   wire [9:0]         sar_result;
   wire               busy;
   wire               load_now;
   wire [`EVT_W-1:0]  evt;

   // Bus handshake: one wait cycle on every access
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign widx     = avs_address[4:2];
   assign wr_go    = avs_write && ack;
   assign rd_go    = avs_read && !ack;
   assign wr_lane0 = wr_go && avs_byteenable[0];
   assign wbyte    = avs_writedata[7:0];

   // Converter may only run when enabled and not in a low-power mode
   assign run_ok = converter_enable && !idle_mode
                   && !power_down_mode;

   assign busy = (state != S_IDLE);

   // Start request by writing one to the start bit
   assign start_req = wr_lane0 && (widx == `REG_CTRL)
                      && wbyte[`CTRL_START];

   // Refuse while a conversion or its flag is pending,
   // or while the minimum conversion period has not elapsed
   assign start_ok = start_req && run_ok && !conversion_start
                     && !conversion_done_flag
                     && (rate_cnt == 8'h00);

   assign load_now = (state == S_LOAD) && step_tick;

   assign evt[`EVT_DONE]    = load_now;
   assign evt[`EVT_REFUSED] = start_req && !start_ok;

   // Interrupt needs the global enable; the done flag also needs the converter enable
   assign irq = global_irq_enable
                && ((converter_irq_enable && conversion_done_flag)
                    || |(irq_status & irq_mask));

   conv_step_timer u_timer
   (
      .mclk  (mclk),
      .rst_n (rst_n),
      .run   (busy),
      .speed (run_speed),
      .tick  (step_tick)
   );

   sar_register u_sar
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clear    (state == S_SAMPLE && step_tick),
      .step     (state == S_CONV && step_tick),
      .cmp_high (cmp_high),
      .trial    (dac_code),
      .result   (sar_result),
      .last     (sar_last)
   );

   // Sequencer next state
   always @*
   begin
      next_state = state;
      case (state)
         S_IDLE:
         begin
            if (start_ok)
               next_state = S_SAMPLE;
         end
         S_SAMPLE:
         begin
            if (step_tick)
               next_state = S_CONV;
         end
         S_CONV:
         begin
            if (step_tick && sar_last)
               next_state = S_LOAD;
         end
         S_LOAD:
         begin
            if (step_tick)
               next_state = S_IDLE;
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
      if (!run_ok)
         next_state = S_IDLE;
   end

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= S_IDLE;
         run_speed <= 2'h0;
      end
      else
      begin
         state <= next_state;
         if (start_ok)
            run_speed <= conv_speed_sel;
      end
   end

   // Rate limiter between starts
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rate_cnt <= 8'h00;
      else if (start_ok)
         rate_cnt <= THROTTLE - 8'h01;
      else if (rate_cnt != 8'h00)
         rate_cnt <= rate_cnt - 8'h01;
   end

   // Analog front end controls
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         converter_on_bit <= 1'b0;
         analog_input_mux <= 3'h0;
         sample_hold      <= 1'b0;
      end
      else
      begin
         converter_on_bit <= run_ok;
         analog_input_mux <= input_channel_select;
         sample_hold      <= (next_state == S_SAMPLE);
      end
   end

   // Control register
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         converter_enable     <= CTRL_INIT[`CTRL_EN];
         conv_speed_sel       <= 2'h0;
         input_channel_select <= 3'h0;
         conversion_start     <= 1'b0;
         conversion_done_flag <= 1'b0;
      end
      else
      begin
         if (wr_lane0 && widx == `REG_CTRL)
         begin
            converter_enable     <= wbyte[`CTRL_EN];
            conv_speed_sel       <= wbyte[`CTRL_SPD_HI:`CTRL_SPD_LO];
            input_channel_select <= wbyte[`CTRL_CHS_HI:`CTRL_CHS_LO];
            if (!wbyte[`CTRL_DONE])
               conversion_done_flag <= 1'b0;
         end
         // Hardware set wins over a software clear
         if (load_now)
            conversion_done_flag <= 1'b1;
         if (start_ok)
            conversion_start <= 1'b1;
         else if (load_now || (busy && !run_ok))
            conversion_start <= 1'b0;
      end
   end

   // Auxiliary, enable and mask registers
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_justify_sel   <= 1'b0;
         converter_irq_enable <= 1'b0;
         global_irq_enable    <= 1'b0;
         irq_mask             <= {`EVT_W{1'b0}};
      end
      else if (wr_lane0)
      begin
         case (widx)
            `REG_AUX:
               result_justify_sel <= wbyte[`AUX_JUSTIFY];
            `REG_IRQ_EN:
            begin
               converter_irq_enable <= wbyte[`IEN_CONV];
               global_irq_enable    <= wbyte[`IEN_GLOBAL];
            end
            `REG_MASK:
               irq_mask <= wbyte[`EVT_W-1:0];
            default:
               irq_mask <= irq_mask;
         endcase
      end
   end

   // Sticky event bits, write one to clear, set wins
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_status <= {`EVT_W{1'b0}};
      else if (wr_lane0 && widx == `REG_STATUS)
         irq_status <= (irq_status & ~wbyte[`EVT_W-1:0]) | evt;
      else
         irq_status <= irq_status | evt;
   end

   // Result bytes, held until the next completion
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_high_byte <= `RES_RST;
         result_low_byte  <= `RES_RST;
      end
      else if (load_now)
      begin
         if (result_justify_sel)
         begin
            result_high_byte <= {6'h00, sar_result[9:8]};
            result_low_byte  <= sar_result[7:0];
         end
         else
         begin
            result_high_byte <= sar_result[9:2];
            result_low_byte  <= {6'h00, sar_result[1:0]};
         end
      end
   end

   // Read data and acknowledge
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack          <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         ack <= (avs_read || avs_write) && !ack;
         if (rd_go)
         begin
            case (widx)
               `REG_CTRL:
                  avs_readdata <= {24'h000000, converter_enable,
                                   conv_speed_sel,
                                   conversion_done_flag,
                                   conversion_start,
                                   input_channel_select};
               `REG_AUX:
                  avs_readdata <= {29'h00000000,
                                   result_justify_sel, 2'h0};
               `REG_RES_HI:
                  avs_readdata <= {24'h000000, result_high_byte};
               `REG_RES_LO:
                  avs_readdata <= {24'h000000, result_low_byte};
               `REG_IRQ_EN:
                  avs_readdata <= {30'h00000000, global_irq_enable,
                                   converter_irq_enable};
               `REG_STATUS:
                  avs_readdata <= {30'h00000000, irq_status};
               `REG_MASK:
                  avs_readdata <= {30'h00000000, irq_mask};
               `REG_STATE:
                  avs_readdata <= {24'h000000, rate_cnt != 8'h00,
                                   run_speed, converter_on_bit,
                                   state};
               default:
                  avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // sar_adc_conversion_control
`default_nettype wire

// file: tb/analog_pins_model.sv
// Behavioural analog pins and comparator facing the converter
`timescale 1ns/1ps
`default_nettype none
module analog_pins_model
(
   // Front end from the block
   input  wire logic        converter_on_bit,
   input  wire logic [2:0]  analog_input_mux,
   input  wire logic [9:0]  dac_code,
   // Pin levels as codes, channel 0 lowest
   input  wire logic [79:0] pin_level,
   // Comparator
   output logic             cmp_high
);
   // Pins held input-only, no digital driver on them
   // Selected pin against ground, full scale 1024 codes
   assign cmp_high = converter_on_bit
      && (pin_level[analog_input_mux * 10 +: 10] >= dac_code);
endmodule // analog_pins_model
`default_nettype wire

// file: tb/sar_adc_checker_assertions.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_checker
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // Register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Modes, front end, interrupt
   input wire logic        idle_mode,
   input wire logic        power_down_mode,
   input wire logic        converter_on_bit,
   input wire logic        sample_hold,
   input wire logic        irq
);
   int gap;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Cycles since the last sample start
   always @(posedge mclk or negedge rst_n)
      if (!rst_n)
         gap <= 1000;
      else if ($rose(sample_hold))
         gap <= 1;
      else if (gap < 1000)
         gap <= gap + 1;
   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet;
      !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_quiet: assert property (p_quiet) else $error("wait unasked");
   property p_read_hold;
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("data moved");
   property p_mode_off;
      idle_mode || power_down_mode |=> !converter_on_bit;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("on in mode");
   property p_on_cause;
      $rose(converter_on_bit) |-> !$past(idle_mode) && !$past(power_down_mode);
   endproperty
   a_on_cause: assert property (p_on_cause) else $error("bad power up");
   property p_no_sample;
      (idle_mode || power_down_mode) [*2] |-> !sample_hold;
   endproperty
   a_no_sample: assert property (p_no_sample) else $error("sampling");
   property p_sample_len;
      $rose(sample_hold) |-> sample_hold [*4];
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("short");
   property p_rate;
      $rose(sample_hold) |-> gap >= 125;
   endproperty
   a_rate: assert property (p_rate) else $error("starts too close");
   property p_irq_fall;
      $fell(irq) |-> $past(avs_write);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
   c_sample: cover property ($rose(sample_hold));
   c_irq: cover property ($rose(irq));
   c_write: cover property (avs_write && !avs_waitrequest);
endmodule // sar_adc_checker
bind sar_adc_conversion_control sar_adc_checker u_sar_adc_checker
(
   .mclk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .idle_mode, .power_down_mode, .converter_on_bit, .sample_hold, .irq
);
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [4:0] ctl = 5'h00, aux = 5'h04, rhi = 5'h08;
   localparam logic [4:0] rlo = 5'h0C, ien = 5'h10, sts = 5'h14;
   localparam logic [4:0] msk = 5'h18, stt = 5'h1C;
   logic        mclk = 0;
   logic        rst_n = 0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 0;
   logic        avs_write = 0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        idle_mode = 0;
   logic        power_down_mode = 0;
   logic        converter_on_bit;
   logic [2:0]  analog_input_mux;
   logic        sample_hold;
   logic [9:0]  dac_code;
   logic        cmp_high;
   logic        irq;
   logic [79:0] pin_level = {10'h07E, 10'h301, 10'h0FF, 10'h2AA,
                             10'h155, 10'h200, 10'h3FF, 10'h000};
   logic [31:0] r;
   int          fail_count = 0;
   int          checks = 0;
   int          cyc = 0;
   always #20 mclk = ~mclk;
   sar_adc_conversion_control u_sar_adc_conversion_control
   (
      .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .idle_mode,
      .power_down_mode, .converter_on_bit, .analog_input_mux, .sample_hold,
      .dac_code, .cmp_high, .irq
   );
   analog_pins_model u_analog_pins_model
   (
      .converter_on_bit, .analog_input_mux, .dac_code, .pin_level, .cmp_high
   );
   task automatic give_verdict();
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; rw high writes
   task automatic bus(input logic rw, input logic [4:0] a,
                      input logic [7:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !rw;
      avs_write <= rw;
      do
         @(posedge mclk);
      while (avs_waitrequest);
      r = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask
   task automatic see_irq(input logic exp);
      @(negedge mclk);
      chk(irq, exp);
   endtask
   task automatic refuse();
      bus(1, ctl, 8'h88);
      bus(0, ctl, 8'h00);
      chk(r, 32'h80);
      avs_byteenable <= 4'h0;
      bus(1, ctl, 8'h00);
      avs_byteenable <= 4'h1;
      bus(0, ctl, 8'h00);
      chk(r, 32'h80);
      bus(0, sts, 8'h00);
      chk(r[1], 1);
   endtask
   task automatic convert(input int ch);
      logic [9:0] v;
      logic [1:0] s;
      logic       j;
      int         t0;
      int         n;
      v = pin_level[ch * 10 +: 10];
      s = ch[1:0];
      j = ch[2];
      n = 60 * (s + 1);
      bus(1, aux, {5'h0, j, 2'h0});
      bus(1, ctl, {1'b1, s, 2'h0, ch[2:0]});
      repeat (130) @(posedge mclk);
      chk(analog_input_mux, ch[2:0]);
      bus(1, ctl, {1'b1, s, 2'h1, ch[2:0]});
      t0 = cyc;
      r = 32'h0;
      while (!r[4])
         bus(0, ctl, 8'h00);
      chk(r[3], 0);
      chk(cyc - t0 >= n - 2 && cyc - t0 <= n + 6, 1);
      bus(0, rhi, 8'h00);
      chk(r, j ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
      bus(0, rlo, 8'h00);
      chk(r, j ? {24'h0, v[7:0]} : {30'h0, v[1:0]});
   endtask
   task automatic irqs();
      bus(1, ien, 8'h01);
      see_irq(0);
      bus(1, ien, 8'h03);
      see_irq(1);
      bus(1, ctl, 8'h80);
      see_irq(0);
      bus(1, msk, 8'h01);
      see_irq(1);
      bus(1, sts, 8'h03);
      see_irq(0);
      bus(0, sts, 8'h00);
      chk(r, 0);
      bus(1, msk, 8'h00);
   endtask
   task automatic abort();
      repeat (130) @(posedge mclk);
      bus(1, ctl, 8'h89);
      bus(1, ctl, 8'h81);
      bus(0, ctl, 8'h00);
      chk(r[3], 1);
      bus(0, stt, 8'h00);
      chk(r[7:4], 4'h9);
      idle_mode <= 1;
      repeat (3) @(posedge mclk);
      chk(converter_on_bit, 0);
      idle_mode <= 0;
      bus(1, ctl, 8'h89);
      repeat (300) @(posedge mclk);
      bus(0, ctl, 8'h00);
      chk(r[4:3], 0);
      bus(0, sts, 8'h00);
      chk(r[1:0], 2'h2);
      bus(0, rlo, 8'h00);
      chk(r, {24'h0, pin_level[77:70]});
      bus(1, ctl, 8'h00);
      power_down_mode <= 1;
      repeat (3) @(posedge mclk);
      chk(converter_on_bit, 0);
      power_down_mode <= 0;
      repeat (3) @(posedge mclk);
      chk(converter_on_bit, 0);
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_n <= 1;
      for (int a = 0; a < 16; a += 4)
      begin
         bus(0, a[4:0], 8'h00);
         chk(r, 0);
      end
      refuse();
      for (int c = 0; c < 8; c++)
         convert(c);
      bus(1, ctl, 8'h98);
      bus(0, ctl, 8'h00);
      chk(r[4:3], 2'h2);
      irqs();
      abort();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
